// ==== analog_comparator_control.sv ====
// analog comparator control: enables, selects, polarity, pin drive, mismatch interrupt logic
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module analog_comparator_control (
    // clock and reset
    input  wire  logic        ref_clk,
    input  wire  logic        reset,
    input  wire  logic        clkEn,
    // wishbone slave
    input  wire  logic        wb_cyc_i,
    input  wire  logic        wb_stb_i,
    input  wire  logic        wb_we_i,
    input  wire  logic [3:0]  wb_adr_i,
    input  wire  logic [3:0]  wb_sel_i,
    input  wire  logic [31:0] wb_dat_i,
    output logic       [31:0] wb_dat_o,
    output logic              wb_ack_o,
    output logic              wb_err_o,
    // raw analog comparison results, asynchronous
    input  wire  logic [1:0]  cmpRaw,
    // analog front end controls
    output logic       [1:0]  cmpPowerOn,
    output logic       [1:0]  cmpFastMode,
    output logic       [1:0]  refSelInternal,
    output logic       [3:0]  channelSel,
    // output pins and port override
    input  wire  logic [1:0]  pinDirection,
    input  wire  logic [1:0]  portLatch,
    output logic       [1:0]  cmpPinOut,
    output logic       [1:0]  cmpPinOe_n,
    // interrupt request
    output logic              irqRequest
);

    logic [7:0]  ctrl_r [2];
    logic [7:0]  shared_r;
    logic [5:0]  flag_r;
    logic [1:0]  sync1_r;
    logic [1:0]  sync2_r;
    logic [1:0]  phase_r;
    logic [1:0]  cycleLatch_r;
    logic [1:0]  readLatch_r;
    logic [1:0]  mismatchPrev_r;
    logic [1:0]  result;
    logic [1:0]  mismatch;
    logic [1:0]  mismatchRise;
    logic [1:0]  ctrlAccess;
    logic        access;
    logic        mapped;
    logic        phaseOne;
    logic [31:0] rdData;

    assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped   = wb_adr_i == cmp_ctrl_pkg::CONTROL1_OFS
                   || wb_adr_i == cmp_ctrl_pkg::CONTROL2_OFS
                   || wb_adr_i == cmp_ctrl_pkg::SHARED_OFS
                   || wb_adr_i == cmp_ctrl_pkg::FLAG_OFS;
    assign phaseOne = phase_r == cmp_ctrl_pkg::PHASE_ONE;

    // bus answer, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clkEn) begin
            wb_ack_o <= access && mapped;
            wb_err_o <= access && !mapped;
            wb_dat_o <= rdData;
        end
    end

    // instruction cycle phase counter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= cmp_ctrl_pkg::PHASE_ONE;
        end else if (clkEn) begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // raw input synchroniser
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else if (clkEn) begin
            sync1_r <= cmpRaw;
            sync2_r <= sync1_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            logic [3:0] ofs;
            logic       raw;
            assign ofs = (g == 0) ? cmp_ctrl_pkg::CONTROL1_OFS : cmp_ctrl_pkg::CONTROL2_OFS;
            assign ctrlAccess[g] = access && wb_adr_i == ofs;
            // disabled comparator holds low so the invert bit sets the result
            assign raw = ctrl_r[g][cmp_ctrl_pkg::ENABLE_BIT] && sync2_r[g];
            assign result[g] = cycleLatch_r[g];
            assign mismatch[g] = cycleLatch_r[g] ^ readLatch_r[g];
            assign mismatchRise[g] = mismatch[g] && !mismatchPrev_r[g];

            // control register: result bit is read only
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    ctrl_r[g] <= cmp_ctrl_pkg::CONTROL_RESET;
                end else if (clkEn && ctrlAccess[g] && wb_we_i && wb_sel_i[0]) begin
                    ctrl_r[g] <= wb_dat_i[7:0] & ~(8'h01 << cmp_ctrl_pkg::RESULT_BIT);
                end
            end

            // cycle latch with polarity
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    cycleLatch_r[g] <= 1'b0;
                end else if (clkEn && phaseOne) begin
                    cycleLatch_r[g] <= raw ^ ctrl_r[g][cmp_ctrl_pkg::INVERT_BIT];
                end
            end

            // read latch updated by any read or write of its own control register
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    readLatch_r[g] <= 1'b0;
                end else if (clkEn && ctrlAccess[g]) begin
                    readLatch_r[g] <= cycleLatch_r[g];
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    mismatchPrev_r[g] <= 1'b0;
                end else if (clkEn) begin
                    mismatchPrev_r[g] <= mismatch[g];
                end
            end

            // front end controls and pin drive
            assign cmpPowerOn[g]     = ctrl_r[g][cmp_ctrl_pkg::ENABLE_BIT];
            assign cmpFastMode[g]    = ctrl_r[g][cmp_ctrl_pkg::SPEED_BIT];
            assign refSelInternal[g] = ctrl_r[g][cmp_ctrl_pkg::REF_BIT];
            assign channelSel[2*g +: 2] = ctrl_r[g][cmp_ctrl_pkg::CH_LSB +: 2];
            // pin output unlatched: raw synchronised value through polarity
            assign cmpPinOut[g] = ctrl_r[g][cmp_ctrl_pkg::DRIVE_BIT]
                ? ((sync2_r[g] && ctrl_r[g][cmp_ctrl_pkg::ENABLE_BIT])
                   ^ ctrl_r[g][cmp_ctrl_pkg::INVERT_BIT])
                : portLatch[g];
            assign cmpPinOe_n[g] = !(ctrl_r[g][cmp_ctrl_pkg::DRIVE_BIT]
                && ctrl_r[g][cmp_ctrl_pkg::ENABLE_BIT] && !pinDirection[g]);
        end
    endgenerate

    // shared control register: spare bits writable, mirror bits read only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shared_r <= cmp_ctrl_pkg::SHARED_RESET;
        end else if (clkEn && access && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == cmp_ctrl_pkg::SHARED_OFS) begin
            shared_r <= {wb_dat_i[7:2], 2'h0};
        end
    end

    // flags and enables; hardware set wins over software clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_r <= cmp_ctrl_pkg::FLAG_RESET;
        end else if (clkEn) begin
            if (access && wb_we_i && wb_sel_i[0] && wb_adr_i == cmp_ctrl_pkg::FLAG_OFS) begin
                flag_r <= wb_dat_i[5:0] | {4'h0, mismatchRise};
            end else begin
                flag_r[cmp_ctrl_pkg::FLAG_LSB +: 2] <= flag_r[cmp_ctrl_pkg::FLAG_LSB +: 2]
                    | mismatchRise;
            end
        end
    end

    assign irqRequest = flag_r[cmp_ctrl_pkg::GLOBAL_BIT] && flag_r[cmp_ctrl_pkg::PERIPH_BIT]
        && |(flag_r[cmp_ctrl_pkg::FLAG_LSB +: 2] & flag_r[cmp_ctrl_pkg::IEN_LSB +: 2]);

    // read multiplexer
    always_comb begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            cmp_ctrl_pkg::CONTROL1_OFS: begin
                rdData[7:0] = ctrl_r[0] | ({7'h00, result[0]} << cmp_ctrl_pkg::RESULT_BIT);
            end
            cmp_ctrl_pkg::CONTROL2_OFS: begin
                rdData[7:0] = ctrl_r[1] | ({7'h00, result[1]} << cmp_ctrl_pkg::RESULT_BIT);
            end
            cmp_ctrl_pkg::SHARED_OFS: begin
                rdData[7:0] = shared_r | {6'h00, result};
            end
            cmp_ctrl_pkg::FLAG_OFS: begin
                rdData[5:0] = flag_r;
            end
            default: begin
                rdData = 32'h0000_0000;
            end
        endcase
    end

endmodule // analog_comparator_control

`default_nettype wire

// ==== analog_comparator_control_assertions.sv ====
// checker: port assertions of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_checker (
    // clock, reset and bus
    input wire logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    // pins and interrupt
    input wire logic        irqRequest,
    input wire logic [1:0]  cmpPowerOn, cmpFastMode, pinDirection, portLatch, cmpPinOut,
    input wire logic [1:0]  cmpPinOe_n,
    input wire logic [3:0]  channelSel
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    chk_ack_answer:
        assert property (req && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o) else $error("no ack");
    chk_err_unmapped:
        assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
            else $error("no err");
    chk_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ctrl_fields:
        assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 4'h0 |->
            cmpPowerOn[0] == $past(wb_dat_i[7]) && cmpFastMode[0] == $past(wb_dat_i[3])
            && channelSel[1:0] == $past(wb_dat_i[1:0])) else $error("fields");
    chk_pin_enable:
        assert property ((~cmpPinOe_n & (~cmpPowerOn | pinDirection)) == 2'h0)
            else $error("drive");
    chk_pin_override:
        assert property (!cmpPinOe_n[0] && $changed(portLatch[0]) |-> $stable(cmpPinOut[0]))
            else $error("leak");
    chk_irq_gate:
        assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 4'hc
            && !$past(wb_dat_i[5]) |-> !irqRequest) else $error("irq");
    chk_reset_state:
        assert property ($fell(reset) |-> cmpPowerOn == 2'h0 && cmpPinOe_n == 2'h3 && !irqRequest)
            else $error("reset");
    cover property (req && wb_we_i);
    cover property (wb_err_o);
    cover property ($rose(irqRequest));
endmodule // analog_comparator_control_checker
`default_nettype wire

// ==== cmp_ctrl_pkg.sv ====
// package: register map, field positions and reset values of the comparator control block
package cmp_ctrl_pkg;
    // register word offsets (byte addresses on the bus)
    localparam logic [3:0] CONTROL1_OFS = 4'h0;
    localparam logic [3:0] CONTROL2_OFS = 4'h4;
    localparam logic [3:0] SHARED_OFS   = 4'h8;
    localparam logic [3:0] FLAG_OFS     = 4'hc;
    // control register fields
    localparam int CH_LSB     = 0;
    localparam int REF_BIT    = 2;
    localparam int SPEED_BIT  = 3;
    localparam int INVERT_BIT = 4;
    localparam int DRIVE_BIT  = 5;
    localparam int RESULT_BIT = 6;
    localparam int ENABLE_BIT = 7;
    // shared control register: result mirrors in bits 1:0, spare writable bits 7:2
    localparam int MIRROR_LSB = 0;
    // flag/enable register: flags 1:0, irq enables 3:2, peripheral 4, global 5
    localparam int FLAG_LSB   = 0;
    localparam int IEN_LSB    = 2;
    localparam int PERIPH_BIT = 4;
    localparam int GLOBAL_BIT = 5;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SHARED_RESET  = 8'h00;
    localparam logic [5:0] FLAG_RESET    = 6'h00;
    // instruction cycle is four clocks; phase one is count zero
    localparam logic [1:0] PHASE_ONE     = 2'h0;
endpackage : cmp_ctrl_pkg

// ==== testbench.sv ====
// testbench: bus, pin and interrupt tests of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'h0, reset = 1'h1;
    logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0]  wb_adr_i = 4'h0, channelSel;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, wb_err_o, irqRequest;
    logic [1:0]  cmpRaw = 2'h0, pinDirection = 2'h0, portLatch = 2'h3;
    logic [1:0]  cmpPowerOn, cmpFastMode, refSelInternal, cmpPinOut, cmpPinOe_n;
    int          miscompares = 0, comparisons = 0, cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    analog_comparator_control u_dut (.ref_clk, .reset, .clkEn(1'h1), .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .cmpRaw, .cmpPowerOn, .cmpFastMode, .refSelInternal, .channelSel, .pinDirection,
        .portLatch, .cmpPinOut, .cmpPinOe_n, .irqRequest);
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; a read compares {err, data} with v
    task automatic xfer(input logic we, input logic [3:0] a, input logic [8:0] v);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 24'h0, v[7:0]};
        @(posedge ref_clk);
        while (!(wb_ack_o || wb_err_o)) @(posedge ref_clk);
        if (!we) check({wb_err_o, wb_dat_o[7:0]}, v);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge ref_clk);
    endtask
    task automatic step(input logic r, input logic [8:0] e);
        cmpRaw[0] <= r;
        repeat (10) @(posedge ref_clk);
        xfer(1'h0, 4'hc, e);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'h0;
        xfer(1'h0, 4'h0, 9'h000);
        xfer(1'h0, 4'hc, 9'h000);
        xfer(1'h0, 4'h2, 9'h100);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            xfer(1'h1, 4'h4, 9'h080 | 9'(i));
            check(9'(channelSel[3:2]), 9'(i));
        end
        check(9'(cmpPowerOn), 9'h002);
        check(9'({refSelInternal, cmpFastMode}), 9'h000);
        $display("select test done");
        xfer(1'h1, 4'h0, 9'h02f);
        check(9'({cmpPinOe_n[0], cmpPinOut[0]}), 9'h002);
        check(9'({refSelInternal, cmpFastMode}), 9'h005);
        xfer(1'h1, 4'h0, 9'h0af);
        check(9'({cmpPinOe_n[0], cmpPinOut[0]}), 9'h000);
        portLatch <= 2'h2;
        @(posedge ref_clk);
        pinDirection <= 2'h1;
        @(posedge ref_clk);
        check(9'(cmpPinOe_n[0]), 9'h001);
        $display("pin test done");
        cmpRaw <= 2'h1;
        repeat (10) @(posedge ref_clk);
        xfer(1'h0, 4'h0, 9'h0ef);
        xfer(1'h0, 4'h8, 9'h001);
        check(9'(cmpPinOut[0]), 9'h001);
        xfer(1'h1, 4'h0, 9'h0bf);
        repeat (10) @(posedge ref_clk);
        xfer(1'h0, 4'h0, 9'h0bf);
        $display("result test done");
        xfer(1'h1, 4'hc, 9'h03c);
        step(1'h0, 9'h03d);
        check(9'(irqRequest), 9'h001);
        xfer(1'h1, 4'hc, 9'h01c);
        xfer(1'h1, 4'hc, 9'h01d);
        xfer(1'h0, 4'hc, 9'h01d);
        check(9'(irqRequest), 9'h000);
        xfer(1'h1, 4'hc, 9'h03c);
        step(1'h0, 9'h03c);
        step(1'h1, 9'h03c);
        step(1'h0, 9'h03d);
        xfer(1'h1, 4'hc, 9'h03c);
        xfer(1'h0, 4'h0, 9'h0ff);
        step(1'h1, 9'h03d);
        xfer(1'h1, 4'hc, 9'h03c);
        xfer(1'h0, 4'h8, 9'h000);
        step(1'h0, 9'h03c);
        $display("interrupt test done");
        give_verdict();
    end
endmodule // testbench
bind analog_comparator_control analog_comparator_control_checker u_chk (.ref_clk, .reset,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_err_o, .wb_adr_i, .wb_dat_i, .irqRequest,
    .cmpPowerOn, .cmpFastMode, .pinDirection, .portLatch, .cmpPinOut, .cmpPinOe_n, .channelSel);
`default_nettype wire
